// ===== core/fault_regs_pkg.sv
// constants and carrier types for the fault and measurement register group
package fault_regs_pkg;
	localparam logic [7:0] OFS_FAULT = 8'h03;
	localparam logic [7:0] OFS_SENSE = 8'h04;
	localparam logic [7:0] OFS_OUTV = 8'h05;
	localparam logic [7:0] OFS_AUX = 8'h06;
	localparam int BIT_ODC = 7;
	localparam int BIT_ODB = 6;
	localparam int BIT_SHORT = 5;
	localparam int BIT_ENCHG = 4;
	localparam int BIT_PBAD = 3;
	localparam int BIT_OC = 2;
	localparam int BIT_UV = 1;
	localparam int BIT_OV = 0;
	localparam logic [7:0] FAULT_RST = 8'h80;
	localparam logic [7:0] RESULT_RST = 8'h00;
	localparam logic [5:0] ALERT_EN_RST = 6'h00;
	localparam logic [7:0] FLAG_MASK = 8'h3f;
	// sense code for 1 mV at 151 uV per count: 6 counts is 0.906 mV, so 7 counts (1.057 mV) exceeds it
	localparam int SHORT_UV_THRESH = 1000;
	localparam int SENSE_LSB_NV = 151000;
	localparam logic [7:0] SHORT_CODE = 8'((SHORT_UV_THRESH * 1000) / SENSE_LSB_NV);

	// host register access
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// live analog-side conditions
	typedef struct packed {
		logic pass_off;
		logic enable_n;
		logic power_good_feedback;
		logic overcurrent;
		logic undervoltage_input;
		logic overvoltage_input;
	} cond_t;

	// conversion results with their update strobes
	typedef struct packed {
		logic sense_vld;
		logic [7:0] sense;
		logic outv_vld;
		logic [7:0] outv;
		logic aux_vld;
		logic [7:0] aux;
	} adc_t;
endpackage

// ===== core/fault_adc_regs.sv
// fault flags, open-drain output controls and adc result registers
// Operation
// - fault bit 7 pulls third open-drain pin low when 1; resets to 1.
// - fault bit 6 pulls second open-drain pin low when 1; resets to 0.
// - bit 5 sets when sense exceeds 1 mV while pass transistor is off.
// - bit 4 sets when active-low enable pin changes level.
// - bit 3 sets when power-good feedback input is low.
// - bit 1 sets when undervoltage input goes low.
// - bit 0 sets when overvoltage input goes high.
// - sense result stored unsigned 8 bits, 151 uV per count.
// - output voltage result stored unsigned 8 bits, 60.5 mV per count.
// - aux input result stored unsigned 8 bits, 4.82 mV per count.
// - each fault asserts alert only when its enable bit is 1; enables reset 0.
module fault_adc_regs
	import fault_regs_pkg::*;
(
	input wire logic core_clk, // core clock, 200 MHz
	input wire logic rst, // async reset, active high
	input fault_regs_pkg::reg_req_t req, // host write request, one cycle
	output logic [7:0] rdata, // read data for req.addr
	input wire logic [5:0] alert_enable, // alert enables from the alert register
	input fault_regs_pkg::cond_t cond, // live conditions
	input fault_regs_pkg::adc_t adc, // conversion results
	input wire logic open_drain_out_b_in, // second pin level
	input wire logic open_drain_out_c_in, // third pin level
	output logic open_drain_out_b_o, // second pin output value
	output logic open_drain_out_b_oe_n, // second pin enable, low drives
	output logic open_drain_out_c_o, // third pin output value
	output logic open_drain_out_c_oe_n, // third pin enable, low drives
	output logic alert // alert request, level
);
	import fault_regs_pkg::*;

	logic [7:0] fault_r, fault_nxt;
	logic [7:0] sense_r, sense_nxt;
	logic [7:0] outv_r, outv_nxt;
	logic [7:0] aux_r, aux_nxt;
	logic en_prev_r, en_prev_nxt;
	logic uv_prev_r, uv_prev_nxt;
	logic ov_prev_r, ov_prev_nxt;
	logic armed_r, armed_nxt;
	logic [7:0] events;
	logic alert_r, alert_nxt;

	function automatic logic hit(input reg_req_t r, input logic [7:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction

	always_comb begin
		events = 8'h00;
		events[BIT_SHORT] = cond.pass_off && (sense_r > SHORT_CODE);
		events[BIT_ENCHG] = armed_r && (cond.enable_n != en_prev_r);
		events[BIT_PBAD] = !cond.power_good_feedback;
		events[BIT_OC] = cond.overcurrent;
		events[BIT_UV] = armed_r && uv_prev_r && !cond.undervoltage_input;
		events[BIT_OV] = armed_r && !ov_prev_r && cond.overvoltage_input;
	end

	always_comb begin
		fault_nxt = fault_r;
		sense_nxt = sense_r;
		outv_nxt = outv_r;
		aux_nxt = aux_r;
		en_prev_nxt = cond.enable_n;
		uv_prev_nxt = cond.undervoltage_input;
		ov_prev_nxt = cond.overvoltage_input;
		armed_nxt = 1'b1;
		if (hit(req, OFS_FAULT)) begin
			fault_nxt[BIT_ODC] = req.wdata[BIT_ODC];
			fault_nxt[BIT_ODB] = req.wdata[BIT_ODB];
			fault_nxt = (fault_nxt & ~FLAG_MASK) | (fault_r & req.wdata & FLAG_MASK);
		end
		// set wins over a clearing write
		fault_nxt = fault_nxt | (events & FLAG_MASK);
		if (adc.sense_vld) begin
			sense_nxt = adc.sense;
		end else if (hit(req, OFS_SENSE)) begin
			sense_nxt = req.wdata;
		end
		if (adc.outv_vld) begin
			outv_nxt = adc.outv;
		end else if (hit(req, OFS_OUTV)) begin
			outv_nxt = req.wdata;
		end
		if (adc.aux_vld) begin
			aux_nxt = adc.aux;
		end else if (hit(req, OFS_AUX)) begin
			aux_nxt = req.wdata;
		end
		alert_nxt = |(fault_r[5:0] & alert_enable);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fault_r <= FAULT_RST;
			sense_r <= RESULT_RST;
			outv_r <= RESULT_RST;
			aux_r <= RESULT_RST;
			en_prev_r <= 1'b0;
			uv_prev_r <= 1'b0;
			ov_prev_r <= 1'b0;
			armed_r <= 1'b0;
			alert_r <= 1'b0;
		end else begin
			fault_r <= fault_nxt;
			sense_r <= sense_nxt;
			outv_r <= outv_nxt;
			aux_r <= aux_nxt;
			en_prev_r <= en_prev_nxt;
			uv_prev_r <= uv_prev_nxt;
			ov_prev_r <= ov_prev_nxt;
			armed_r <= armed_nxt;
			alert_r <= alert_nxt;
		end
	end

	always_comb begin
		unique case (req.addr)
			OFS_FAULT: rdata = fault_r;
			OFS_SENSE: rdata = sense_r;
			OFS_OUTV: rdata = outv_r;
			OFS_AUX: rdata = aux_r;
			default: rdata = 8'h00;
		endcase
	end

	// pins only ever pull low; the pin levels are unused here
	assign open_drain_out_c_o = 1'b0;
	assign open_drain_out_c_oe_n = !fault_r[BIT_ODC];
	assign open_drain_out_b_o = 1'b0;
	assign open_drain_out_b_oe_n = !fault_r[BIT_ODB];
	assign alert = alert_r;

	property p_od_c;
		@(posedge core_clk) disable iff (rst)
			hit(req, OFS_FAULT) |=> open_drain_out_c_oe_n == !$past(req.wdata[BIT_ODC]);
	endproperty
	a_od_c: assert property (p_od_c) else $error("third pin not updated");

	// pins move only on a fault register write, never on flag events
	property p_od_c_keep;
		@(posedge core_clk) disable iff (rst)
			!hit(req, OFS_FAULT) |=> $stable(open_drain_out_c_oe_n);
	endproperty
	a_od_c_keep: assert property (p_od_c_keep) else $error("third pin moved");

	property p_od_b;
		@(posedge core_clk) disable iff (rst)
			hit(req, OFS_FAULT) |=> open_drain_out_b_oe_n == !$past(req.wdata[BIT_ODB]);
	endproperty
	a_od_b: assert property (p_od_b) else $error("second pin not updated");

	property p_od_b_keep;
		@(posedge core_clk) disable iff (rst)
			!hit(req, OFS_FAULT) |=> $stable(open_drain_out_b_oe_n);
	endproperty
	a_od_b_keep: assert property (p_od_b_keep) else $error("second pin moved");

	property p_short;
		@(posedge core_clk) disable iff (rst)
			(cond.pass_off && sense_r > SHORT_CODE) |=> fault_r[BIT_SHORT];
	endproperty
	a_short: assert property (p_short) else $error("short flag missed");

	property p_enchg;
		@(posedge core_clk) disable iff (rst)
			(armed_r && cond.enable_n != en_prev_r) |=> fault_r[BIT_ENCHG];
	endproperty
	a_enchg: assert property (p_enchg) else $error("enable change missed");

	property p_pbad;
		@(posedge core_clk) disable iff (rst) !cond.power_good_feedback |=> fault_r[BIT_PBAD];
	endproperty
	a_pbad: assert property (p_pbad) else $error("power bad missed");

	property p_uv;
		@(posedge core_clk) disable iff (rst)
			(armed_r && $fell(cond.undervoltage_input)) |=> fault_r[BIT_UV];
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage missed");

	property p_ov;
		@(posedge core_clk) disable iff (rst)
			(armed_r && $rose(cond.overvoltage_input)) |=> fault_r[BIT_OV];
	endproperty
	a_ov: assert property (p_ov) else $error("overvoltage missed");

	property p_oc;
		@(posedge core_clk) disable iff (rst)
			cond.overcurrent |=> fault_r[BIT_OC];
	endproperty
	a_oc: assert property (p_oc) else $error("overcurrent missed");

	property p_sense;
		@(posedge core_clk) disable iff (rst) adc.sense_vld |=> sense_r == $past(adc.sense);
	endproperty
	a_sense: assert property (p_sense) else $error("sense not stored");

	property p_sense_wr;
		@(posedge core_clk) disable iff (rst)
			(hit(req, OFS_SENSE) && !adc.sense_vld) |=> sense_r == $past(req.wdata);
	endproperty
	a_sense_wr: assert property (p_sense_wr) else $error("sense write lost");

	property p_sense_keep;
		@(posedge core_clk) disable iff (rst)
			(!hit(req, OFS_SENSE) && !adc.sense_vld) |=> $stable(sense_r);
	endproperty
	a_sense_keep: assert property (p_sense_keep) else $error("sense changed");

	property p_outv;
		@(posedge core_clk) disable iff (rst)
			adc.outv_vld |=> outv_r == $past(adc.outv);
	endproperty
	a_outv: assert property (p_outv) else $error("output voltage not stored");

	property p_outv_keep;
		@(posedge core_clk) disable iff (rst)
			(!hit(req, OFS_OUTV) && !adc.outv_vld) |=> $stable(outv_r);
	endproperty
	a_outv_keep: assert property (p_outv_keep) else $error("output voltage changed");

	property p_aux;
		@(posedge core_clk) disable iff (rst)
			adc.aux_vld |=> aux_r == $past(adc.aux);
	endproperty
	a_aux: assert property (p_aux) else $error("aux result not stored");

	property p_aux_keep;
		@(posedge core_clk) disable iff (rst)
			(!hit(req, OFS_AUX) && !adc.aux_vld) |=> $stable(aux_r);
	endproperty
	a_aux_keep: assert property (p_aux_keep) else $error("aux result changed");

	property p_alert;
		@(posedge core_clk) disable iff (rst)
			alert |-> |($past(fault_r[5:0]) & $past(alert_enable));
	endproperty
	a_alert: assert property (p_alert) else $error("alert without enabled flag");

	property p_alert_on;
		@(posedge core_clk) disable iff (rst)
			|(fault_r[5:0] & alert_enable) |=> alert;
	endproperty
	a_alert_on: assert property (p_alert_on) else $error("enabled flag gave no alert");

	property p_alert_off;
		@(posedge core_clk) disable iff (rst)
			!(|(fault_r[5:0] & alert_enable)) |=> !alert;
	endproperty
	a_alert_off: assert property (p_alert_off) else $error("alert stuck");

	property p_hold;
		@(posedge core_clk) disable iff (rst)
			(fault_r[BIT_OC] && !(hit(req, OFS_FAULT) && !req.wdata[BIT_OC])) |=> fault_r[BIT_OC];
	endproperty
	a_hold: assert property (p_hold) else $error("flag dropped without clear");

	property p_hold_pbad;
		@(posedge core_clk) disable iff (rst)
			(fault_r[BIT_PBAD] && !(hit(req, OFS_FAULT) && !req.wdata[BIT_PBAD]))
				|=> fault_r[BIT_PBAD];
	endproperty
	a_hold_pbad: assert property (p_hold_pbad) else $error("power bad dropped");

	// a zero written while no new event arrives must clear the flag
	property p_clear_ov;
		@(posedge core_clk) disable iff (rst)
			(hit(req, OFS_FAULT) && !req.wdata[BIT_OV] && !$rose(cond.overvoltage_input))
				|=> !fault_r[BIT_OV];
	endproperty
	a_clear_ov: assert property (p_clear_ov) else $error("overvoltage not cleared");

	// writing a one must never manufacture a flag
	property p_noset_uv;
		@(posedge core_clk) disable iff (rst)
			(hit(req, OFS_FAULT) && req.wdata[BIT_UV] && !fault_r[BIT_UV]
				&& !$fell(cond.undervoltage_input)) |=> !fault_r[BIT_UV];
	endproperty
	a_noset_uv: assert property (p_noset_uv) else $error("write set a flag");

	property p_clear_enchg;
		@(posedge core_clk) disable iff (rst)
			(hit(req, OFS_FAULT) && !req.wdata[BIT_ENCHG] && !$changed(cond.enable_n))
				|=> !fault_r[BIT_ENCHG];
	endproperty
	a_clear_enchg: assert property (p_clear_enchg) else $error("enable flag not cleared");

	c_short: cover property (@(posedge core_clk) disable iff (rst) $rose(fault_r[BIT_SHORT]));
	c_clear: cover property (@(posedge core_clk) disable iff (rst) $fell(fault_r[BIT_OV]));
	c_alert: cover property (@(posedge core_clk) disable iff (rst) $rose(alert));
	c_enchg: cover property (@(posedge core_clk) disable iff (rst) $rose(fault_r[BIT_ENCHG]));
	c_set_wins: cover property (@(posedge core_clk) disable iff (rst)
		hit(req, OFS_FAULT) && !req.wdata[BIT_OC] && cond.overcurrent);
endmodule // fault_adc_regs

// ===== verification/host_model.sv
// register host model: writes and reads over the block's own access port
module host_model (
	input wire logic core_clk, // core clock
	input wire logic [7:0] rdata, // read data from the block
	output fault_regs_pkg::reg_req_t req // register request
);
	timeunit 1ns;
	timeprecision 1ps;
	import fault_regs_pkg::*;
	initial req = '0;
	// flags cleared only by writing 0
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		req <= '{wr: 1'b1, addr: a, wdata: d};
		@(negedge core_clk);
		req.wr <= 1'b0;
	endtask
	// read data is combinational: taken a full cycle after the address moves,
	// so the caller resumes on a falling edge like every other stimulus
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		req.addr <= a;
		@(negedge core_clk);
		d = rdata;
	endtask
endmodule // host_model

// ===== verification/fault_and_adc_result_registers_test.sv
// bench for the fault flag and adc result register group
module fault_and_adc_result_registers_test;
	timeunit 1ns;
	timeprecision 1ps;
	import fault_regs_pkg::*;
	logic core_clk, rst;
	reg_req_t req;
	logic [7:0] rdata, d, f;
	logic [5:0] alert_enable;
	cond_t cond;
	adc_t adc;
	logic b_o, b_oe_n, c_o, c_oe_n, alert;
	int fails, n_compared, cyc;
	host_model host (.core_clk(core_clk), .rdata(rdata), .req(req));
	// pins pulled up: level is low only while driven
	fault_adc_regs DUT (.core_clk(core_clk), .rst(rst), .req(req), .rdata(rdata),
		.alert_enable(alert_enable), .cond(cond), .adc(adc),
		.open_drain_out_b_in(b_oe_n), .open_drain_out_c_in(c_oe_n),
		.open_drain_out_b_o(b_o), .open_drain_out_b_oe_n(b_oe_n),
		.open_drain_out_c_o(c_o), .open_drain_out_c_oe_n(c_oe_n), .alert(alert));
	initial begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk(d, e);
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic setc(input int i, input logic on);
		case (i)
			0: cond.overvoltage_input = on;
			1: cond.undervoltage_input = !on;
			2: cond.overcurrent = on;
			3: cond.power_good_feedback = !on;
			4: cond.enable_n = !on;
			default: adc.sense = on ? 8'h07 : 8'h06;
		endcase
	endtask
	task summarize;
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ceiling well above the roughly 180 cycles of the sequence
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		fails = 0;
		n_compared = 0;
		cyc = 0;
		rst = 1;
		alert_enable = '0;
		adc = '0;
		cond = '{pass_off: 0, enable_n: 1, power_good_feedback: 1, overcurrent: 0,
			undervoltage_input: 1, overvoltage_input: 0};
		wt(3);
		rst = 0;
		rchk(OFS_FAULT, FAULT_RST);
		chk({4'h0, c_oe_n, b_oe_n, c_o, b_o}, 8'h04);
		for (int i = 0; i < 3; i++)
			rchk(8'(OFS_SENSE + i), RESULT_RST);
		host.wr(OFS_FAULT, 8'h7f);
		rchk(OFS_FAULT, 8'h40);
		chk({4'h0, c_oe_n, b_oe_n, c_o, b_o}, 8'h08);
		// six counts is just below the short threshold
		cond.pass_off = 1;
		adc.sense = 8'h06;
		adc.sense_vld = 1;
		wt(3);
		rchk(OFS_FAULT, 8'h40);
		for (int i = 0; i < 6; i++) begin
			f = 8'h40 | 8'(1 << i);
			setc(i, 1);
			wt(3);
			chk({7'h0, alert}, 8'h00);
			rchk(OFS_FAULT, f);
			alert_enable = 6'(1 << i);
			wt(2);
			chk({7'h0, alert}, 8'h01);
			host.wr(OFS_FAULT, f);
			rchk(OFS_FAULT, f);
			setc(i, 0);
			wt(3);
			host.wr(OFS_FAULT, 8'h40);
			rchk(OFS_FAULT, 8'h40);
			wt(2);
			chk({7'h0, alert}, 8'h00);
			alert_enable = '0;
		end
		// a clearing write loses against a condition that still stands
		setc(2, 1);
		wt(2);
		host.wr(OFS_FAULT, 8'h40);
		rchk(OFS_FAULT, 8'h44);
		setc(2, 0);
		host.wr(OFS_FAULT, 8'h40);
		rchk(OFS_FAULT, 8'h40);
		adc.sense_vld = 0;
		cond.pass_off = 0;
		adc.sense = 8'hff;
		adc.outv = 8'hfe;
		adc.aux = 8'hfd;
		for (int i = 0; i < 3; i++) begin
			host.wr(8'(OFS_SENSE + i), 8'h5a);
			rchk(8'(OFS_SENSE + i), 8'h5a);
			adc.sense_vld = (i == 0);
			adc.outv_vld = (i == 1);
			adc.aux_vld = (i == 2);
			wt(1);
			adc.sense_vld = 0;
			adc.outv_vld = 0;
			adc.aux_vld = 0;
			rchk(8'(OFS_SENSE + i), 8'hff - 8'(i));
		end
		rchk(8'h07, 8'h00);
		rchk(8'h02, 8'h00);
		// second reset in mid-run brings back the defaults
		rst = 1;
		wt(1);
		rst = 0;
		rchk(OFS_FAULT, FAULT_RST);
		rchk(OFS_SENSE, RESULT_RST);
		summarize();
	end
endmodule // fault_and_adc_result_registers_test
